// ---- inc/apc_defines.vh ----
// apc_defines.vh: register indices, field positions and reset values of the audio port block.
// assumes a byte-addressed bus where a register's byte address is four times its index.
`ifndef APC_DEFINES_VH
`define APC_DEFINES_VH

// ----------------------------------------
// register indices
// ----------------------------------------
`define APC_IDX_CTRL0 7'h18
`define APC_IDX_CTRL1 7'h19
`define APC_IDX_BCLK_DIV 7'h1A
`define APC_IDX_FRAME 7'h1B
`define APC_IDX_STATUS 7'h1C
`define APC_IDX_PATH 7'h1D

// ----------------------------------------
// field positions
// ----------------------------------------
`define APC_LOOPBACK 8
`define APC_TX_COMP 3
`define APC_TX_LAW 2
`define APC_RX_COMP 1
`define APC_RX_LAW 0
`define APC_BCLK_DIR 6
`define APC_FRAME_POL 4
`define APC_FMT_HI 1
`define APC_FMT_LO 0
`define APC_FRAME_DIR 11
`define APC_MIC_EN 0
`define APC_DAC_EN 1
`define APC_SIDETONE 2

// ----------------------------------------
// reset values, dsp format code and word length
// ----------------------------------------
`define APC_RST_CTRL0 16'h0050
`define APC_RST_CTRL1 16'h000A
`define APC_RST_BCLK_DIV 16'h0004
`define APC_RST_FRAME 16'h0040
`define APC_RST_PATH 16'h0000
`define APC_FMT_DSP 2'h3
`define APC_WORD_BITS 4'h8

`endif

// ---- rtl/apc_audio_port.v ----
// apc_audio_port.v: audio serial port clocking, 8-bit companding and loopback with an avalon-mm register slave.
// assumes one system clock, microphone samples arriving on that clock, and pins synchronised here.
//
// Behaviour
// - bit clock pin is input when its direction bit is 0, driven when 1.
// - frame clock pin is input when its direction bit is 0, driven when 1.
// - master clocks run only while a microphone channel or the dac is enabled.
// - in slave mode both clock outputs stay undriven by default.
// - the two direction bits act independently, allowing mixed master and slave.
// - master bit clock is system clock divided by the ratio the 5-bit code selects from a table, default 4.
// - master frame clock is bit clock divided by 11-bit rate, 8 to 2047, default 64.
// - transmit companding enabled by bit 3; bit 2 picks mu-law (0) or a-law (1).
// - receive companding enabled by bit 1; bit 0 picks mu-law (0) or a-law (1).
// - companding uses segment approximation of mu 255 and a 87.6 curves.
// - mu-law codes invert all bits; a-law codes invert even bits only.
// - the 8-bit word occupies the first eight msb positions of the slot.
// - compressor maps 13-bit (mu) or 12-bit (a) magnitude to 8 bits.
// - word holds sign in bit 7, exponent 6:4, mantissa 3:0.
// - any companding enable selects 8-bit words, frames down to 8 bit clocks.
// - dsp mode b allows back-to-back 8-bit words every 8 bit clocks with an input frame clock; a driven frame clock needs a rate of 9.
// - with both enables 0, either law bit selects uncompanded 8-bit mode.
// - loopback bit 8 routes microphone data straight into the dac path.
// - in loopback the receive serial data is ignored.
// - with sidetone on, microphone data is also summed into the dac path.
// - in dsp format polarity 0 puts msb on second bit clock edge, 1 on first.
`include "apc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module apc_audio_port #(
  parameter RATE_W = 11
) (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire [8:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  input wire bclk_i,
  output reg bclk_o,
  output wire bclk_oe_o,
  input wire lrclk_i,
  output reg lrclk_o,
  output wire lrclk_oe_o,
  input wire rx_serial_data_i,
  output reg tx_serial_data_o,
  input wire [15:0] mic_sample_i,
  input wire mic_valid_i,
  output reg [15:0] dac_sample_o,
  output reg dac_valid_o
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // twice the divide ratio, so that the 1.5 and 5.5 codes stay integral
  function [7:0] div_x2;
    input [4:0] code;
    begin
      case (code)
        5'h00: div_x2 = 8'h02;
        5'h01: div_x2 = 8'h03;
        5'h02: div_x2 = 8'h04;
        5'h03: div_x2 = 8'h06;
        5'h04: div_x2 = 8'h08;
        5'h05: div_x2 = 8'h0A;
        5'h06: div_x2 = 8'h0B;
        5'h07: div_x2 = 8'h0C;
        5'h08: div_x2 = 8'h10;
        5'h09: div_x2 = 8'h14;
        5'h0A: div_x2 = 8'h16;
        5'h0B: div_x2 = 8'h18;
        5'h0C: div_x2 = 8'h20;
        5'h0D: div_x2 = 8'h28;
        5'h0E: div_x2 = 8'h2C;
        5'h0F: div_x2 = 8'h30;
        5'h10: div_x2 = 8'h32;
        5'h11: div_x2 = 8'h3C;
        5'h12: div_x2 = 8'h40;
        5'h13: div_x2 = 8'h58;
        // codes above the table fall back to the slowest ratio
        default: div_x2 = 8'h60;
      endcase
    end
  endfunction

  function [7:0] compress;
    input [15:0] lin;
    input alaw;
    reg [15:0] mag;
    reg [12:0] m;
    reg [2:0] e;
    reg [3:0] man;
    integer i;
    begin
      mag = lin[15] ? (~lin + 16'h0001) : lin;
      // full-scale negative has no positive twin, so clip it to the largest magnitude
      if (mag[15]) mag = 16'h7FFF;
      if (alaw) begin
        m = {1'b0, mag[14:3]};
        e = 3'h0;
        for (i = 5; i <= 11; i = i + 1) begin
          if (m[i]) e = i[2:0] - 3'h4;
        end
        man = (e == 3'h0) ? m[4:1] : m[e +: 4];
        compress = {~lin[15], e, man} ^ 8'h55;
      end else begin
        m = (mag[14:2] > 13'h1FDE) ? 13'h1FFF : mag[14:2] + 13'h0021;
        e = 3'h0;
        for (i = 6; i <= 12; i = i + 1) begin
          if (m[i]) e = i[2:0] - 3'h5;
        end
        man = m[{1'b0, e} + 4'h1 +: 4];
        compress = ~{lin[15], e, man};
      end
    end
  endfunction

  function [15:0] expand;
    input [7:0] code;
    input alaw;
    reg [7:0] c;
    reg [13:0] mag;
    begin
      if (alaw) begin
        c = code ^ 8'h55;
        // both laws rebuild the middle of the segment step, except a-law segment 0 which gives its lower end, then scale up to the 16-bit sample
        if (c[6:4] != 3'h0) mag = ({9'h000, 1'b1, c[3:0]} << c[6:4]) | ({13'h0000, 1'b1} << (c[6:4] - 3'h1));
        else mag = {8'h00, c[3:0], 2'h1} >> 1;
        expand = c[7] ? {1'b0, mag[11:0], 3'h0} : (~{1'b0, mag[11:0], 3'h0} + 16'h0001);
      end else begin
        c = ~code;
        mag = (({9'h000, 1'b1, c[3:0]} << ({1'b0, c[6:4]} + 4'h1)) | ({13'h0000, 1'b1} << c[6:4])) - 14'h0021;
        expand = c[7] ? (~{1'b0, mag[12:0], 2'h0} + 16'h0001) : {1'b0, mag[12:0], 2'h0};
      end
    end
  endfunction

  // ----------------------------------------
  // register slave
  // ----------------------------------------
  reg [15:0] ctrl0_q;
  reg [15:0] ctrl1_q;
  reg [15:0] bclk_div_q;
  reg [15:0] frame_q;
  reg [15:0] path_q;
  reg ack_q;
  reg [7:0] rx_byte_q;
  wire req = avs_read_i | avs_write_i;
  wire [6:0] idx = avs_address_i[8:2];
  // a write lands on the edge that ends the cycle after its single wait cycle
  wire do_wr = avs_write_i & ack_q;
  wire [15:0] wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [15:0] wval = avs_writedata_i[15:0];
  wire eight_bit = ctrl0_q[`APC_TX_COMP] | ctrl0_q[`APC_RX_COMP] |
    ctrl0_q[`APC_TX_LAW] | ctrl0_q[`APC_RX_LAW];
  wire clk_run;
  reg [15:0] status;

  // one wait cycle per access keeps the read mux out of the bus path
  assign avs_waitrequest_o = req & ~ack_q;

  // status is read-only and echoes the last received word for software
  always @* begin
    status = {rx_byte_q, 6'h00, eight_bit, clk_run};
  end

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ack_q <= 1'b0;
      avs_readdata_o <= 32'h00000000;
      ctrl0_q <= `APC_RST_CTRL0;
      ctrl1_q <= `APC_RST_CTRL1;
      bclk_div_q <= `APC_RST_BCLK_DIV;
      frame_q <= `APC_RST_FRAME;
      path_q <= `APC_RST_PATH;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        case (idx)
          `APC_IDX_CTRL0: avs_readdata_o <= {16'h0000, ctrl0_q};
          `APC_IDX_CTRL1: avs_readdata_o <= {16'h0000, ctrl1_q};
          `APC_IDX_BCLK_DIV: avs_readdata_o <= {16'h0000, bclk_div_q};
          `APC_IDX_FRAME: avs_readdata_o <= {16'h0000, frame_q};
          `APC_IDX_STATUS: avs_readdata_o <= {16'h0000, status};
          `APC_IDX_PATH: avs_readdata_o <= {16'h0000, path_q};
          default: avs_readdata_o <= 32'h00000000;
        endcase
      end
      // reserved bits are masked off so they always read back as zero
      if (do_wr) begin
        case (idx)
          `APC_IDX_CTRL0: ctrl0_q <= (ctrl0_q & ~wmask) | (wval & wmask & 16'h01FF);
          `APC_IDX_CTRL1: ctrl1_q <= (ctrl1_q & ~wmask) | (wval & wmask & 16'h3FDF);
          `APC_IDX_BCLK_DIV: bclk_div_q <= (bclk_div_q & ~wmask) | (wval & wmask & 16'h001F);
          `APC_IDX_FRAME: frame_q <= (frame_q & ~wmask) | (wval & wmask & 16'h0FFF);
          `APC_IDX_PATH: path_q <= (path_q & ~wmask) | (wval & wmask & 16'h0007);
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // the third stage feeds only the edge detectors; only the second stage reads the first
  reg [2:0] bclk_s_q;
  reg [2:0] lrclk_s_q;
  reg [1:0] rxd_s_q;
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      bclk_s_q <= 3'h0;
      lrclk_s_q <= 3'h0;
      rxd_s_q <= 2'h0;
    end else begin
      bclk_s_q <= {bclk_s_q[1:0], bclk_i};
      lrclk_s_q <= {lrclk_s_q[1:0], lrclk_i};
      rxd_s_q <= {rxd_s_q[0], rx_serial_data_i};
    end
  end

  // ----------------------------------------
  // bit clock generation
  // ----------------------------------------
  // each direction bit alone picks its pin, so mixed master and slave needs no mode of its own
  wire bclk_out = ctrl1_q[`APC_BCLK_DIR];
  wire lrclk_out = frame_q[`APC_FRAME_DIR];
  assign bclk_oe_o = bclk_out;
  assign lrclk_oe_o = lrclk_out;
  assign clk_run = path_q[`APC_MIC_EN] | path_q[`APC_DAC_EN];

  // toggles average 4/(2*ratio) per cycle; ratios under 2 saturate at one toggle a cycle
  reg [7:0] acc_q;
  reg [7:0] acc_d;
  reg tog;
  wire [7:0] t2 = div_x2(bclk_div_q[4:0]);
  always @* begin
    acc_d = acc_q + 8'h04;
    tog = 1'b0;
    if (acc_d >= t2) begin
      acc_d = acc_d - t2;
      tog = 1'b1;
    end
    // a code change can leave the residue past the new limit, so clear it rather than wrap
    if (acc_d >= t2) acc_d = 8'h00;
  end

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      acc_q <= 8'h00;
      bclk_o <= 1'b0;
    end else if (clk_run) begin
      acc_q <= acc_d;
      if (tog) bclk_o <= ~bclk_o;
    end else begin
      acc_q <= 8'h00;
      bclk_o <= 1'b0;
    end
  end

  // internal edges when driving, synchronised pin edges when listening
  wire int_rise = clk_run & tog & ~bclk_o;
  wire int_fall = clk_run & tog & bclk_o;
  wire bit_rise = bclk_out ? int_rise : (bclk_s_q[1] & ~bclk_s_q[2]);
  wire bit_fall = bclk_out ? int_fall : (~bclk_s_q[1] & bclk_s_q[2]);

  // ----------------------------------------
  // frame clock generation
  // ----------------------------------------
  reg [RATE_W-1:0] fcnt_q;
  // rates under the minimum of 8 are clamped rather than left to run a short frame
  wire [RATE_W-1:0] rate = (frame_q[RATE_W-1:0] < 11'd8) ? 11'd8 : frame_q[RATE_W-1:0];
  wire dsp = (ctrl1_q[`APC_FMT_HI:`APC_FMT_LO] == `APC_FMT_DSP);
  wire frame_start = lrclk_out ? (bit_rise & (fcnt_q == rate - 11'd1)) :
    (lrclk_s_q[1] & ~lrclk_s_q[2]);

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      fcnt_q <= {RATE_W{1'b0}};
      lrclk_o <= 1'b0;
    end else if (!clk_run) begin
      fcnt_q <= {RATE_W{1'b0}};
      lrclk_o <= 1'b0;
    end else if (bit_rise) begin
      fcnt_q <= (fcnt_q >= rate - 11'd1) ? {RATE_W{1'b0}} : fcnt_q + 11'd1;
      if (dsp) lrclk_o <= (fcnt_q >= rate - 11'd1);
      else lrclk_o <= (fcnt_q >= rate - 11'd1) | (fcnt_q < (rate >> 1) - 11'd1);
    end
  end

  // ----------------------------------------
  // serial slot, 8-bit words
  // ----------------------------------------
  // bits_q counts the slot: 0 idle, otherwise bit positions still owed
  reg [3:0] bits_q;
  reg skip_q;
  reg [7:0] rx_sh_q;
  reg [7:0] tx_sh_q;
  reg rx_done_q;
  // tx moves on the falling edge so the far side samples a settled bit on its rising one
  wire [7:0] tx_word = ctrl0_q[`APC_TX_COMP] ?
    compress(mic_sample_i, ctrl0_q[`APC_TX_LAW]) : mic_sample_i[15:8];
  wire mode_b = ctrl1_q[`APC_FRAME_POL];

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      bits_q <= 4'h0;
      skip_q <= 1'b0;
      rx_sh_q <= 8'h00;
      tx_sh_q <= 8'h00;
      rx_done_q <= 1'b0;
      rx_byte_q <= 8'h00;
      tx_serial_data_o <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (frame_start & eight_bit) begin
        // mode b takes the msb on the first rising edge, mode a on the second
        bits_q <= `APC_WORD_BITS;
        skip_q <= dsp & ~mode_b;
        tx_sh_q <= tx_word;
        tx_serial_data_o <= tx_word[7];
      end else if (bit_rise & (bits_q != 4'h0)) begin
        if (skip_q) skip_q <= 1'b0;
        else begin
          rx_sh_q <= {rx_sh_q[6:0], rxd_s_q[1]};
          bits_q <= bits_q - 4'h1;
          if (bits_q == 4'h1) begin
            rx_done_q <= 1'b1;
            rx_byte_q <= {rx_sh_q[6:0], rxd_s_q[1]};
          end
        end
      end else if (bit_fall & (bits_q != 4'h0) & ~skip_q & (bits_q != `APC_WORD_BITS)) begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        tx_serial_data_o <= tx_sh_q[6];
      end
    end
  end

  // ----------------------------------------
  // dac path
  // ----------------------------------------
  wire loopback = ctrl0_q[`APC_LOOPBACK];
  wire sidetone = path_q[`APC_SIDETONE];
  wire [15:0] rx_lin = ctrl0_q[`APC_RX_COMP] ?
    expand(rx_byte_q, ctrl0_q[`APC_RX_LAW]) : {rx_byte_q, 8'h00};
  wire [15:0] base = loopback ? mic_sample_i : rx_lin;
  wire [16:0] sum = {base[15], base} + {mic_sample_i[15], mic_sample_i};
  // summing saturates instead of wrapping, a wrap would be a full-scale click
  wire [15:0] mixed = (sum[16] != sum[15]) ? (sum[16] ? 16'h8000 : 16'h7FFF) : sum[15:0];
  // loopback takes the microphone strobe, otherwise each finished receive word
  wire take = loopback ? mic_valid_i : rx_done_q;
  wire take_d = sidetone & ~loopback ? rx_done_q : take;

  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      dac_sample_o <= 16'h0000;
      dac_valid_o <= 1'b0;
    end else begin
      dac_valid_o <= take_d & path_q[`APC_DAC_EN];
      if (take_d) dac_sample_o <= sidetone ? mixed : base;
    end
  end

endmodule
`default_nettype wire

// ---- tb/apc_audio_port_sva.sv ----
// apc_audio_port_sva.sv: port-level assertions for the audio port block.
// assumes it is bound to apc_audio_port and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module apc_audio_port_sva (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [8:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic bclk_o,
  input wire logic bclk_oe_o,
  input wire logic lrclk_oe_o,
  input wire logic dac_valid_o
);
  // ----
  // shadow of path enable and divider code, seen only through bus writes
  // ----
  logic [2:0] path_q;
  logic [4:0] div_q;
  wire wr_ack = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      path_q <= 3'h0;
      div_q <= 5'h04;
    end else if (wr_ack && avs_address_i[8:2] == 7'h1D) begin
      path_q <= avs_writedata_i[2:0];
    end else if (wr_ack && avs_address_i[8:2] == 7'h1A) begin
      div_q <= avs_writedata_i[4:0];
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  sequence acc_s; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
  sequence ack_s; (avs_read_i || avs_write_i) && !avs_waitrequest_o; endsequence
  sequence run_s; bclk_oe_o && path_q[1:0] != 2'h0 && div_q == 5'h04; endsequence
  one_wait_a: assert property (acc_s |=> ack_s)
    else $error("bus access did not finish after one wait cycle");
  idle_nowait_a: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("waitrequest high with no request");
  rd_upper_a: assert property (ack_s ##0 avs_read_i |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  bclk_dir_a: assert property (wr_ack && avs_address_i[8:2] == 7'h19
    |=> bclk_oe_o == $past(avs_writedata_i[6]) && $stable(lrclk_oe_o)) else $error("bit clock direction wrong");
  lrclk_dir_a: assert property (ack_s ##0 avs_write_i && avs_byteenable_i[1] && avs_address_i[8:2] == 7'h1B
    |=> lrclk_oe_o == $past(avs_writedata_i[11]) && $stable(bclk_oe_o)) else $error("frame clock direction wrong");
  clk_still_a: assert property ((bclk_oe_o && path_q[1:0] == 2'h0) [*2] |=> $stable(bclk_o))
    else $error("bit clock moves with no channel enabled");
  div_four_a: assert property (run_s ##0 $rose(bclk_o) |=> bclk_o ##1 !bclk_o)
    else $error("bit clock high phase not two cycles");
  dac_pulse_a: assert property (dac_valid_o |=> !dac_valid_o)
    else $error("dac strobe longer than one cycle");
  dac_en_a: assert property (dac_valid_o |-> path_q[1])
    else $error("dac strobe with dac disabled");
endmodule
bind apc_audio_port apc_audio_port_sva u_sva (.clk_sys_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .bclk_o, .bclk_oe_o, .lrclk_oe_o,
  .dac_valid_o);
`default_nettype wire

// ---- tb/apc_far_port.sv ----
// apc_far_port.sv: far audio port acting as clock master in dsp mode b, one 8-bit word each way per frame.
// assumes the system clock as its time base; it runs only while run_i is high.
`timescale 1ns/1ps
`default_nettype none
module apc_far_port #(
  parameter int HALF = 4
) (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [7:0] word_i,
  input wire logic data_i,
  output logic bclk_o,
  output logic lrclk_o,
  output logic data_o,
  output logic [7:0] got_o
);
  int cnt = 0;
  int bitn = 0;
  logic [7:0] sh = 8'h00;
  initial begin
    bclk_o = 1'b0;
    lrclk_o = 1'b0;
    data_o = 1'b0;
    got_o = 8'h00;
  end
  always @(posedge clk_i) begin
    if (!run_i) begin
      bclk_o <= 1'b0; // clock stands still while run_i is low
      lrclk_o <= 1'b0;
      data_o <= ~data_o; // released line shows no stale level
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      bclk_o <= ~bclk_o;
      if (bclk_o) begin
        // falling edge: frame pulse with the msb, words back to back
        lrclk_o <= (bitn == 0);
        data_o <= word_i[7 - bitn];
        bitn <= (bitn + 1) % 8;
        if (bitn == 0) got_o <= sh;
      end else begin
        sh <= {sh[6:0], data_i}; // transmit bit taken on the rising edge
      end
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// tb.sv: self-checking bench for the audio port block.
// assumes the design, its checker bind and the far port model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys_i, rst_b_i, avs_read_i, avs_write_i, mic_valid_i, run;
  logic [8:0] avs_address_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [15:0] mic_sample_i, dac_sample_o;
  logic [7:0] word, got;
  logic avs_waitrequest_o, bclk_o, bclk_oe_o, lrclk_o, lrclk_oe_o, tx_serial_data_o, dac_valid_o;
  logic far_bclk, far_lrclk, far_data;
  int error_cnt = 0;
  int cmp_count = 0;
  int chg;
  typedef struct {logic wr; logic [8:0] a; logic [3:0] be; logic [15:0] d; logic [31:0] e;} apc_row_t;
  // ----
  // register rows: reset values, unmapped place, writes read back, one byte lane
  // ----
  apc_row_t rows[11] = '{
    '{1'b0, 9'h060, 4'hF, 16'h0000, 32'h00000050}, '{1'b0, 9'h064, 4'hF, 16'h0000, 32'h0000000A},
    '{1'b0, 9'h068, 4'hF, 16'h0000, 32'h00000004}, '{1'b0, 9'h06C, 4'hF, 16'h0000, 32'h00000040},
    '{1'b0, 9'h074, 4'hF, 16'h0000, 32'h00000000}, '{1'b0, 9'h1FC, 4'hF, 16'h0000, 32'h00000000},
    '{1'b1, 9'h068, 4'hF, 16'h0014, 32'h00000014}, '{1'b1, 9'h06C, 4'hF, 16'h0808, 32'h00000808},
    '{1'b1, 9'h064, 4'hF, 16'h0053, 32'h00000053}, '{1'b1, 9'h060, 4'hF, 16'h010F, 32'h0000010F},
    '{1'b1, 9'h060, 4'h2, 16'h0000, 32'h0000000F}};
  wire bclk_w = bclk_oe_o ? bclk_o : far_bclk;
  wire lrclk_w = lrclk_oe_o ? lrclk_o : far_lrclk;
  apc_audio_port uut (.clk_sys_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .bclk_i(bclk_w), .bclk_o, .bclk_oe_o,
    .lrclk_i(lrclk_w), .lrclk_o, .lrclk_oe_o, .rx_serial_data_i(far_data), .tx_serial_data_o, .mic_sample_i,
    .mic_valid_i, .dac_sample_o, .dac_valid_o);
  apc_far_port #(.HALF(4)) u_far (.clk_i(clk_sys_i), .run_i(run), .word_i(word), .data_i(tx_serial_data_o),
    .bclk_o(far_bclk), .lrclk_o(far_lrclk), .data_o(far_data), .got_o(got));
  task automatic report_and_stop();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic bail();
    error_cnt++;
    report_and_stop();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic wr, input logic [8:0] a, input logic [3:0] be, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_byteenable_i <= be;
    avs_writedata_i <= {16'h0000, d};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 40);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 40) bail();
    // one more edge so that a write has settled before any output is compared
    @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    bus(1'b1, a, 4'hF, d);
  endtask
  task automatic wv();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (dac_valid_o !== 1'b1 && n < 3000);
    if (n >= 3000) bail();
  endtask
  // cycles between two rising edges of the bit clock (s = 0) or frame clock (s = 1)
  task automatic per(input int s, input int e);
    int n, c, t;
    logic o;
    n = 0;
    c = 0;
    t = 0;
    o = s ? lrclk_o : bclk_o;
    while (n < 2 && c < 400) begin
      @(posedge clk_sys_i);
      c++;
      if ((s ? lrclk_o : bclk_o) === 1'b1 && o === 1'b0) begin
        n++;
        if (n == 1) t = c;
      end
      o = s ? lrclk_o : bclk_o;
    end
    if (c >= 400) bail();
    chk(c - t, e);
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    {rst_b_i, avs_read_i, avs_write_i, mic_valid_i, run} = 5'h00;
    {avs_address_i, avs_byteenable_i, avs_writedata_i, mic_sample_i} = 61'h0;
    word = 8'hFF;
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) bus(1'b1, rows[i].a, rows[i].be, rows[i].d);
      bus(1'b0, rows[i].a, 4'hF, 16'h0000);
      chk(q, rows[i].e);
    end
    chk({30'h0, bclk_oe_o, lrclk_oe_o}, 32'h00000003);
    wr(9'h064, 16'h0013);
    chk({30'h0, bclk_oe_o, lrclk_oe_o}, 32'h00000001);
    wr(9'h064, 16'h0053);
    wr(9'h068, 16'h0004);
    chg = 0;
    repeat (20) begin
      @(posedge clk_sys_i);
      if (bclk_o !== 1'b0 || lrclk_o !== 1'b0) chg++;
    end
    chk(chg, 0);
    wr(9'h074, 16'h0003);
    per(0, 4);
    per(1, 32);
    wr(9'h068, 16'h0003);
    per(0, 3);
    wr(9'h068, 16'h0004);
    // loopback in 8-bit mode: words received from the far side must not reach the dac
    wr(9'h060, 16'h0101);
    run <= 1'b1;
    mic_sample_i <= 16'h1234;
    repeat (2) begin
      @(posedge clk_sys_i) mic_valid_i <= 1'b1;
      @(posedge clk_sys_i) mic_valid_i <= 1'b0;
      wv();
    end
    chk({16'h0000, dac_sample_o}, 32'h00001234);
    wr(9'h074, 16'h0007);
    repeat (2) begin
      @(posedge clk_sys_i) mic_valid_i <= 1'b1;
      @(posedge clk_sys_i) mic_valid_i <= 1'b0;
      wv();
    end
    chk({16'h0000, dac_sample_o}, 32'h00002468);
    // slave, dsp mode b, uncompanded 8-bit words from the far port
    wr(9'h074, 16'h0002);
    word <= 8'hA5;
    wr(9'h064, 16'h0013);
    wr(9'h06C, 16'h0008);
    wr(9'h060, 16'h0001);
    chk({30'h0, bclk_oe_o, lrclk_oe_o}, 32'h00000000);
    wv();
    wv();
    chk({16'h0000, dac_sample_o}, 32'h0000A500);
    chk({24'h000000, got}, 32'h00000012);
    bus(1'b0, 9'h070, 4'hF, 16'h0000);
    chk({24'h000000, q[15:8]}, 32'h000000A5);
    // a-law both ways, then mu-law both ways, on the same far word and microphone sample
    wr(9'h060, 16'h000F);
    wv();
    wv();
    chk({16'h0000, dac_sample_o}, 32'h00004200);
    chk({24'h000000, got}, 32'h00000087);
    wr(9'h060, 16'h000A);
    wv();
    wv();
    chk({16'h0000, dac_sample_o}, 32'h000019FC);
    chk({24'h000000, got}, 32'h000000AD);
    run <= 1'b0;
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    bus(1'b0, 9'h064, 4'hF, 16'h0000);
    chk(q, 32'h0000000A);
    chk({30'h0, bclk_oe_o, lrclk_oe_o}, 32'h00000000);
    report_and_stop();
  end
endmodule
`default_nettype wire
